// ==== hw/fbl_pkg.sv ====
// Package of constants and types for the flash boot loader block
package fbl_pkg;
   // APB register byte offsets
   localparam logic [7:0] FBL_OFS_SEL_UPPER = 8'h00;
   localparam logic [7:0] FBL_OFS_SEL_LOWER = 8'h04;
   localparam logic [7:0] FBL_OFS_CTRL = 8'h08;
   localparam logic [7:0] FBL_OFS_STATUS = 8'h0C;
   localparam logic [7:0] FBL_OFS_DIVISOR = 8'h10;
   // Reset values
   localparam logic [7:0] FBL_SEL_RST = 8'h00;
   localparam logic [15:0] FBL_DIV_RST = 16'h0001;
   // Field positions
   localparam int FBL_CTRL_SWG_BIT = 6;
   localparam int FBL_SEL_TOP_BIT = 7;
   // Handshake byte values
   localparam logic [7:0] FBL_BYTE_ADJ = 8'h00;
   localparam logic [7:0] FBL_BYTE_CONFIRM = 8'h55;
   localparam logic [7:0] FBL_BYTE_OK = 8'hAA;
   localparam logic [7:0] FBL_BYTE_FAIL = 8'hFF;
   // RAM layout of the downloaded program
   localparam logic [23:0] FBL_RAM_BASE = 24'hFFE080;
   localparam logic [23:0] FBL_RAM_ENTRY = 24'hFFE088;
   localparam logic [15:0] FBL_ID_LEN = 16'h0008;
   // Timing: ready delay after reset, in states (clock cycles)
   localparam int FBL_READY_STATES = 100;
   localparam logic [15:0] FBL_READY_CYC = 16'(FBL_READY_STATES);
   // Least reset hold that ends boot mode, in states
   localparam int FBL_RST_HOLD_STATES = 20;
   // Bits low in one zero byte: start plus eight data bits
   localparam logic [3:0] FBL_LOW_BITS_LAST = 4'h8;
   // Frame length: start, eight data, stop
   localparam logic [3:0] FBL_FRAME_LAST = 4'h9;
   // Loader states, one-hot
   typedef enum logic [12:0] {
      FBL_ST_RESET = 13'h0001,
      FBL_ST_USER = 13'h0002,
      FBL_ST_MEASURE = 13'h0004,
      FBL_ST_SEND_ADJ = 13'h0008,
      FBL_ST_WAIT_CONF = 13'h0010,
      FBL_ST_LEN_HI = 13'h0020,
      FBL_ST_LEN_LO = 13'h0040,
      FBL_ST_DATA = 13'h0080,
      FBL_ST_CHECK = 13'h0100,
      FBL_ST_ERASE = 13'h0200,
      FBL_ST_RESULT = 13'h0400,
      FBL_ST_JUMP = 13'h0800,
      FBL_ST_ABORT = 13'h1000
   } fbl_state_t;
endpackage

// ==== hw/fbl_boot_loader.sv ====
// Flash erase-block selection, mode decode and serial boot loader
`timescale 1ns/1ps
module fbl_boot_loader
   import fbl_pkg::*;
#(
   parameter logic [63:0] ID_CODE = 64'h0123_4567_89AB_CDEF // Arbitrary value
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic mode_pin_hi,
   input wire logic mode_pin_lo,
   input wire logic boot_sel_pin_2,
   input wire logic boot_sel_pin_1,
   input wire logic boot_sel_pin_0,
   input wire logic boot_rx_line,
   output logic boot_tx_line,
   input wire logic low_power_mode,
   input wire logic watchdog_overflow,
   input wire logic flash_all_ones,
   output logic erase_req,
   input wire logic erase_done,
   input wire logic erase_fail,
   input wire logic flash_op_busy,
   output logic irq_mask,
   input wire logic [15:0] flash_rd_addr,
   input wire logic flash_rd_word,
   input wire logic [15:0] flash_array_data,
   output logic [15:0] flash_rd_data,
   output logic flash_rd_blocked,
   output logic cpu_normal_mode,
   output logic [7:0] rom_size_kb,
   output logic boot_mode,
   output logic ram_we,
   output logic [23:0] ram_addr,
   output logic [7:0] ram_wdata,
   output logic rx_on,
   output logic tx_on,
   output logic [15:0] baud_divisor,
   output logic boot_jump,
   output logic [23:0] jump_addr
);

   // All state of the block
   typedef struct packed {
      fbl_state_t st;
      logic [5:0] sync1; // First synchroniser stage
      logic [5:0] sync2; // Second synchroniser stage
      logic [15:0] wait_cnt; // Reset delay counter
      logic boot; // Latched boot mode
      logic normal; // Latched normal mode
      logic [7:0] sel_lower; // Erase-block select
      logic swg; // Soft write gate
      logic [15:0] div; // Baud divisor
      logic [3:0] sub9; // Low-time sub counter
      logic [15:0] acc; // Measured bit period
      logic measuring; // Low period in progress
      logic rx_busy;
      logic [15:0] rx_cnt;
      logic [3:0] rx_bit;
      logic [7:0] rx_sh;
      logic rx_valid; // One-cycle byte pulse
      logic tx_busy;
      logic [15:0] tx_cnt;
      logic [3:0] tx_bit;
      logic [9:0] tx_sh;
      logic tx_line;
      logic serial_en;
      logic [15:0] len;
      logic [15:0] idx;
      logic id_ok;
      logic ram_we;
      logic [23:0] ram_addr;
      logic [7:0] ram_wdata;
      logic erase_req;
      logic irq_mask;
      logic jump;
      logic [15:0] frd;
      logic [31:0] prdata;
      logic pslverr;
   } fbl_reg_t;

   fbl_reg_t cur_ff;
   fbl_reg_t nxt_ff;
   logic rx_s; // Synchronised receive line
   logic tx_go; // Start a transmit this cycle
   logic [7:0] tx_byte; // Byte to transmit
   logic [7:0] wsel; // Candidate select value
   logic acc_en; // APB access phase

   assign rx_s = cur_ff.sync2[0];
   assign acc_en = psel & penable;

   // Next-state logic
   always_comb begin
      nxt_ff = cur_ff;
      tx_go = 1'b0;
      tx_byte = FBL_BYTE_ADJ;
      wsel = FBL_SEL_RST;
      nxt_ff.rx_valid = 1'b0;
      nxt_ff.ram_we = 1'b0;
      nxt_ff.jump = 1'b0;
      nxt_ff.pslverr = 1'b0;
      // Pin synchronisers
      nxt_ff.sync1 = {boot_sel_pin_2, boot_sel_pin_1, boot_sel_pin_0,
                      mode_pin_hi, mode_pin_lo, boot_rx_line};
      nxt_ff.sync2 = cur_ff.sync1;

      // Receiver, sampling mid-bit
      if (!cur_ff.serial_en || !cur_ff.rx_busy) begin
         if (cur_ff.serial_en && !rx_s && !cur_ff.st[2]) begin
            nxt_ff.rx_busy = 1'b1;
            nxt_ff.rx_cnt = {1'b0, cur_ff.div[15:1]};
            nxt_ff.rx_bit = 4'h0;
         end
      end else if (cur_ff.rx_cnt != 16'h0000) begin
         nxt_ff.rx_cnt = cur_ff.rx_cnt - 16'h0001;
      end else begin
         nxt_ff.rx_cnt = cur_ff.div - 16'h0001;
         nxt_ff.rx_bit = cur_ff.rx_bit + 4'h1;
         if (cur_ff.rx_bit == 4'h0 && rx_s) begin
            // False start
            nxt_ff.rx_busy = 1'b0;
         end else if (cur_ff.rx_bit == FBL_FRAME_LAST) begin
            // Stop bit; no parity bit in the frame
            nxt_ff.rx_busy = 1'b0;
            nxt_ff.rx_valid = rx_s;
         end else if (cur_ff.rx_bit != 4'h0) begin
            nxt_ff.rx_sh = {rx_s, cur_ff.rx_sh[7:1]};
         end
      end

      // Transmitter shift
      if (cur_ff.tx_busy) begin
         if (cur_ff.tx_cnt != 16'h0000) begin
            nxt_ff.tx_cnt = cur_ff.tx_cnt - 16'h0001;
         end else if (cur_ff.tx_bit == FBL_FRAME_LAST) begin
            nxt_ff.tx_busy = 1'b0;
            nxt_ff.tx_line = 1'b1;
         end else begin
            nxt_ff.tx_cnt = cur_ff.div - 16'h0001;
            nxt_ff.tx_bit = cur_ff.tx_bit + 4'h1;
            nxt_ff.tx_sh = {1'b1, cur_ff.tx_sh[9:1]};
            nxt_ff.tx_line = cur_ff.tx_sh[1];
         end
      end

      // Loader sequence
      case (cur_ff.st)
         FBL_ST_RESET: begin
            nxt_ff.wait_cnt = cur_ff.wait_cnt + 16'h0001;
            if (cur_ff.wait_cnt == FBL_READY_CYC - 16'h0001) begin
               // Straps latched once synchronisers settled
               nxt_ff.normal = cur_ff.sync2[2] & cur_ff.sync2[1];
               nxt_ff.boot = ~cur_ff.sync2[2] & ~cur_ff.sync2[1]
                             & (&cur_ff.sync2[5:3]);
               if (~cur_ff.sync2[2] & ~cur_ff.sync2[1] & (&cur_ff.sync2[5:3])) begin
                  nxt_ff.st = FBL_ST_MEASURE;
                  nxt_ff.serial_en = 1'b1;
               end else begin
                  nxt_ff.st = FBL_ST_USER;
               end
            end
         end
         FBL_ST_MEASURE: begin
            // Low time of a zero byte spans nine bits
            if (!rx_s) begin
               nxt_ff.measuring = 1'b1;
               if (cur_ff.sub9 == FBL_LOW_BITS_LAST) begin
                  nxt_ff.sub9 = 4'h0;
                  nxt_ff.acc = cur_ff.acc + 16'h0001;
               end else begin
                  nxt_ff.sub9 = cur_ff.sub9 + 4'h1;
               end
            end else if (cur_ff.measuring) begin
               nxt_ff.div = (cur_ff.acc == 16'h0000) ? FBL_DIV_RST : cur_ff.acc;
               nxt_ff.st = FBL_ST_SEND_ADJ;
            end
         end
         FBL_ST_SEND_ADJ: begin
            if (!cur_ff.tx_busy) begin
               tx_go = 1'b1;
               tx_byte = FBL_BYTE_ADJ;
               nxt_ff.st = FBL_ST_WAIT_CONF;
            end
         end
         FBL_ST_WAIT_CONF: begin
            // Trailing zero bytes are dropped here
            if (cur_ff.rx_valid && cur_ff.rx_sh == FBL_BYTE_CONFIRM) begin
               tx_go = 1'b1;
               tx_byte = FBL_BYTE_OK;
               nxt_ff.st = FBL_ST_LEN_HI;
            end
         end
         FBL_ST_LEN_HI: begin
            if (cur_ff.rx_valid) begin
               tx_go = 1'b1;
               tx_byte = cur_ff.rx_sh;
               nxt_ff.len = {cur_ff.rx_sh, 8'h00};
               nxt_ff.st = FBL_ST_LEN_LO;
            end
         end
         FBL_ST_LEN_LO: begin
            if (cur_ff.rx_valid) begin
               tx_go = 1'b1;
               tx_byte = cur_ff.rx_sh;
               nxt_ff.len = {cur_ff.len[15:8], cur_ff.rx_sh};
               nxt_ff.idx = 16'h0000;
               nxt_ff.id_ok = 1'b1;
               nxt_ff.ram_addr = FBL_RAM_BASE;
               if ({cur_ff.len[15:8], cur_ff.rx_sh} == 16'h0000) begin
                  nxt_ff.st = FBL_ST_CHECK;
               end else begin
                  nxt_ff.st = FBL_ST_DATA;
               end
            end
         end
         FBL_ST_DATA: begin
            if (cur_ff.rx_valid) begin
               tx_go = 1'b1;
               tx_byte = cur_ff.rx_sh;
               nxt_ff.ram_we = 1'b1;
               nxt_ff.ram_wdata = cur_ff.rx_sh;
               nxt_ff.ram_addr = FBL_RAM_BASE + {8'h00, cur_ff.idx};
               nxt_ff.idx = cur_ff.idx + 16'h0001;
               // Identity bytes compared most significant first
               if (cur_ff.idx < FBL_ID_LEN &&
                   cur_ff.rx_sh != ID_CODE[8'(63 - 8 * cur_ff.idx) -: 8]) begin
                  nxt_ff.id_ok = 1'b0;
               end
               if (cur_ff.idx == cur_ff.len - 16'h0001) begin
                  nxt_ff.st = FBL_ST_CHECK;
               end
            end
         end
         FBL_ST_CHECK: begin
            // Later received bytes fall on no state that takes them
            if (!cur_ff.id_ok || cur_ff.len < FBL_ID_LEN) begin
               nxt_ff.id_ok = 1'b0;
               nxt_ff.st = FBL_ST_RESULT;
            end else if (!flash_all_ones) begin
               nxt_ff.erase_req = 1'b1;
               nxt_ff.st = FBL_ST_ERASE;
            end else begin
               nxt_ff.st = FBL_ST_RESULT;
            end
         end
         FBL_ST_ERASE: begin
            if (erase_fail) begin
               nxt_ff.erase_req = 1'b0;
               nxt_ff.id_ok = 1'b0;
               nxt_ff.st = FBL_ST_RESULT;
            end else if (erase_done) begin
               nxt_ff.erase_req = 1'b0;
               nxt_ff.st = FBL_ST_RESULT;
            end
         end
         FBL_ST_RESULT: begin
            if (!cur_ff.tx_busy) begin
               tx_go = 1'b1;
               tx_byte = cur_ff.id_ok ? FBL_BYTE_OK : FBL_BYTE_FAIL;
               nxt_ff.st = cur_ff.id_ok ? FBL_ST_JUMP : FBL_ST_ABORT;
            end
         end
         FBL_ST_JUMP: begin
            // Wait for the status byte to leave, then stop serial
            if (!cur_ff.tx_busy) begin
               nxt_ff.serial_en = 1'b0;
               nxt_ff.rx_busy = 1'b0;
               nxt_ff.tx_line = 1'b1;
               nxt_ff.jump = 1'b1;
               nxt_ff.st = FBL_ST_USER;
            end
         end
         FBL_ST_ABORT: begin
            nxt_ff.st = FBL_ST_ABORT;
         end
         default: begin
            nxt_ff.st = cur_ff.st;
         end
      endcase

      // Watchdog overflow leaves boot mode
      if (watchdog_overflow) begin
         nxt_ff.boot = 1'b0;
         nxt_ff.serial_en = 1'b0;
         nxt_ff.erase_req = 1'b0;
         nxt_ff.tx_busy = 1'b0;
         nxt_ff.tx_line = 1'b1;
         nxt_ff.st = FBL_ST_USER;
         tx_go = 1'b0;
      end

      // Transmit start
      if (tx_go) begin
         nxt_ff.tx_busy = 1'b1;
         nxt_ff.tx_bit = 4'h0;
         nxt_ff.tx_cnt = cur_ff.div - 16'h0001;
         nxt_ff.tx_sh = {1'b1, tx_byte, 1'b0};
         nxt_ff.tx_line = 1'b0;
      end

      // Interrupt mask while erasing or while a flash operation is busy
      nxt_ff.irq_mask = nxt_ff.erase_req | flash_op_busy;

      // Flash read path, even byte on upper lanes
      if (nxt_ff.irq_mask) begin
         nxt_ff.frd = 16'h0000;
      end else if (flash_rd_word) begin
         nxt_ff.frd = flash_array_data;
      end else if (!flash_rd_addr[0]) begin
         nxt_ff.frd = {8'h00, flash_array_data[15:8]};
      end else begin
         nxt_ff.frd = {8'h00, flash_array_data[7:0]};
      end

      // APB: read data and error load at setup, so they stand at the access edge
      if (psel) begin
         nxt_ff.prdata = 32'h0000_0000;
         if (paddr == FBL_OFS_SEL_UPPER) begin
            nxt_ff.prdata = 32'h0000_0000;
         end else if (paddr == FBL_OFS_SEL_LOWER) begin
            nxt_ff.prdata = {24'h000000, cur_ff.sel_lower};
            if (acc_en && pwrite && cur_ff.swg) begin
               wsel = pwdata[7:0];
               if (cur_ff.normal) begin
                  wsel[FBL_SEL_TOP_BIT] = 1'b0;
               end
               nxt_ff.sel_lower = ((wsel & (wsel - 8'h01)) != 8'h00) ? FBL_SEL_RST : wsel;
            end
         end else if (paddr == FBL_OFS_CTRL) begin
            nxt_ff.prdata = 32'(cur_ff.swg) << FBL_CTRL_SWG_BIT;
            if (acc_en && pwrite) begin
               nxt_ff.swg = pwdata[FBL_CTRL_SWG_BIT];
            end
         end else if (paddr == FBL_OFS_STATUS) begin
            nxt_ff.prdata = {12'h000, cur_ff.irq_mask, cur_ff.id_ok, cur_ff.serial_en,
                             cur_ff.normal, cur_ff.boot, 2'b00, 13'(cur_ff.st)};
         end else if (paddr == FBL_OFS_DIVISOR) begin
            nxt_ff.prdata = {16'h0000, cur_ff.div};
         end else begin
            nxt_ff.pslverr = ~penable;
         end
      end

      // Select register clears; gate-off and low power win
      if (!nxt_ff.swg || low_power_mode) begin
         nxt_ff.sel_lower = FBL_SEL_RST;
      end
   end

   // State register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cur_ff <= '0;
         cur_ff.st <= FBL_ST_RESET;
         cur_ff.sync1 <= 6'h3F;
         cur_ff.sync2 <= 6'h3F;
         cur_ff.sel_lower <= FBL_SEL_RST;
         cur_ff.div <= FBL_DIV_RST;
         cur_ff.tx_line <= 1'b1;
      end else begin
         cur_ff <= nxt_ff;
      end
   end

   // Outputs
   assign pready = 1'b1;
   assign prdata = cur_ff.prdata;
   assign pslverr = cur_ff.pslverr;
   assign boot_tx_line = cur_ff.tx_line;
   assign erase_req = cur_ff.erase_req;
   assign irq_mask = cur_ff.irq_mask;
   assign flash_rd_data = cur_ff.frd;
   assign flash_rd_blocked = cur_ff.irq_mask;
   assign cpu_normal_mode = cur_ff.normal;
   assign rom_size_kb = cur_ff.normal ? 8'h38 : 8'h40;
   assign boot_mode = cur_ff.boot;
   assign ram_we = cur_ff.ram_we;
   assign ram_addr = cur_ff.ram_addr;
   assign ram_wdata = cur_ff.ram_wdata;
   assign rx_on = cur_ff.serial_en;
   assign tx_on = cur_ff.serial_en;
   assign baud_divisor = cur_ff.div;
   assign boot_jump = cur_ff.jump;
   assign jump_addr = FBL_RAM_ENTRY;

endmodule // fbl_boot_loader

// ==== sim/fbl_boot_loader_sva.sv ====
// Port checker for the flash boot loader
`timescale 1ns/1ps
module fbl_boot_loader_sva
   import fbl_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pslverr,
   input wire logic flash_op_busy,
   input wire logic erase_req,
   input wire logic irq_mask,
   input wire logic flash_rd_blocked,
   input wire logic flash_rd_word,
   input wire logic [15:0] flash_array_data,
   input wire logic [15:0] flash_rd_data,
   input wire logic cpu_normal_mode,
   input wire logic [7:0] rom_size_kb,
   input wire logic boot_mode,
   input wire logic boot_jump,
   input wire logic rx_on,
   input wire logic tx_on,
   input wire logic boot_tx_line,
   input wire logic [23:0] jump_addr,
   input wire logic ram_we,
   input wire logic [23:0] ram_addr
);
   // One clock domain, reset disables every check
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   chk_irq_follow: assert property (irq_mask == (erase_req | $past(flash_op_busy)))
      else $error("irq mask does not follow erase or busy");
   chk_block_same: assert property (flash_rd_blocked == irq_mask)
      else $error("read block differs from irq mask");
   chk_block_zero: assert property ($past(flash_op_busy) && $past(flash_op_busy, 2)
      |-> flash_rd_data == 16'h0000)
      else $error("flash read not blanked while busy");
   chk_word_path: assert property ($past(flash_rd_word) && !irq_mask
      |-> flash_rd_data == $past(flash_array_data))
      else $error("word read data wrong");
   chk_rom_map: assert property (rom_size_kb == (cpu_normal_mode ? 8'h38 : 8'h40))
      else $error("rom size wrong for mode");
   chk_jump_quiet: assert property (boot_jump |-> !rx_on && !tx_on && boot_tx_line
      && jump_addr == FBL_RAM_ENTRY)
      else $error("serial still on or bad entry at jump");
   chk_jump_pulse: assert property (boot_jump |=> !boot_jump)
      else $error("jump pulse too long");
   chk_ram_window: assert property (ram_we |-> boot_mode && ram_addr >= FBL_RAM_BASE)
      else $error("ram write outside boot area");
   chk_erase_boot: assert property (erase_req |-> boot_mode)
      else $error("erase outside boot mode");
   chk_tx_idle: assert property (!tx_on |-> boot_tx_line)
      else $error("tx line not idle high");
   chk_err_cause: assert property (pslverr |-> $past(psel && !penable))
      else $error("slave error without access");
endmodule // fbl_boot_loader_sva
bind fbl_boot_loader fbl_boot_loader_sva fbl_boot_loader_sva_i (.ref_clk, .rst, .psel,
   .penable, .pslverr, .flash_op_busy, .erase_req, .irq_mask, .flash_rd_blocked,
   .flash_rd_word, .flash_array_data, .flash_rd_data, .cpu_normal_mode, .rom_size_kb,
   .boot_mode, .boot_jump, .rx_on, .tx_on, .boot_tx_line, .jump_addr, .ram_we, .ram_addr);

// ==== sim/fbl_host_model.sv ====
// Host side of the boot serial link
`timescale 1ns/1ps
module fbl_host_model #(
   parameter int BIT = 16 // Host bit time in clocks
) (
   input wire logic ref_clk,
   input wire logic boot_tx_line,
   output logic boot_rx_line
);
   logic [7:0] rx_q[$]; // Bytes heard from the device
   int frame_err = 0; // Stop bits seen low
   initial boot_rx_line = 1'b1; // Idle high at reset end
   // 8N1 LSB first; start bit 4 clocks longer than BIT so the measure floors to BIT
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         boot_rx_line <= f[i];
         repeat (i == 0 ? BIT + 4 : BIT) @(posedge ref_clk);
      end
   endtask
   // Receiver: mid-bit sampling, stop bit checked
   initial begin : rx_proc
      logic [7:0] d;
      forever begin
         @(posedge ref_clk);
         if (boot_tx_line === 1'b0) begin
            repeat (BIT / 2) @(posedge ref_clk);
            for (int i = 0; i < 8; i++) begin
               repeat (BIT) @(posedge ref_clk);
               d[i] = boot_tx_line;
            end
            repeat (BIT) @(posedge ref_clk);
            if (boot_tx_line !== 1'b1) begin
               frame_err++;
            end
            rx_q.push_back(d);
         end
      end
   end
endmodule // fbl_host_model

// ==== sim/tb_top.sv ====
// Testbench for the flash boot loader
`timescale 1ns/1ps
module tb_top;
   import fbl_pkg::*;
   localparam int BIT = 16; // Host bit time in clocks
   localparam logic [63:0] BOOT_ID = 64'h5A17_C3E9_0B44_2D61; // Arbitrary value
   logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, rerr, fail_mode;
   logic [7:0] paddr, rom_size_kb, ram_wdata;
   logic [31:0] pwdata, prdata, rdata, seed = 32'h1812, rnd = 32'h1812;
   logic mode_pin_hi, mode_pin_lo, boot_sel_pin_2, boot_sel_pin_1, boot_sel_pin_0;
   logic boot_rx_line, boot_tx_line, low_power_mode, watchdog_overflow, flash_all_ones;
   logic erase_req, erase_done, erase_fail, flash_op_busy, irq_mask, flash_rd_word;
   logic [15:0] flash_rd_addr, flash_array_data, flash_rd_data, baud_divisor;
   logic flash_rd_blocked, cpu_normal_mode, boot_mode, ram_we, rx_on, tx_on, boot_jump;
   logic [23:0] ram_addr, jump_addr;
   logic [23:0] ram_a[$]; // Observed RAM write addresses
   logic [7:0] ram_d[$]; // Observed RAM write data
   int err_count = 0, n_tests = 0, jumps = 0, cyc = 0;
   fbl_boot_loader #(.ID_CODE(BOOT_ID)) fbl_boot_loader_i (.ref_clk, .rst, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .mode_pin_hi,
      .mode_pin_lo, .boot_sel_pin_2, .boot_sel_pin_1, .boot_sel_pin_0, .boot_rx_line,
      .boot_tx_line, .low_power_mode, .watchdog_overflow, .flash_all_ones, .erase_req,
      .erase_done, .erase_fail, .flash_op_busy, .irq_mask, .flash_rd_addr, .flash_rd_word,
      .flash_array_data, .flash_rd_data, .flash_rd_blocked, .cpu_normal_mode, .rom_size_kb,
      .boot_mode, .ram_we, .ram_addr, .ram_wdata, .rx_on, .tx_on, .baud_divisor,
      .boot_jump, .jump_addr);
   fbl_host_model #(.BIT(BIT)) fbl_host_model_i (.ref_clk, .boot_tx_line, .boot_rx_line);
   // Xorshift step
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   // Compare and count
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   // Verdict and end of run
   task automatic tally_and_finish();
      $display("tests %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // One APB transfer; data and error taken at the access edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1) @(posedge ref_clk);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask
   // Read a register and compare
   task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 0);
      chk(n, e, rdata);
   endtask
   // Next byte from the host queue, X on timeout
   task automatic get_byte(output logic [7:0] b);
      for (int t = 0; t < 3000 && fbl_host_model_i.rx_q.size() == 0; t++) @(posedge ref_clk);
      b = (fbl_host_model_i.rx_q.size() == 0) ? 8'hXX : fbl_host_model_i.rx_q.pop_front();
   endtask
   // Send a byte and compare the reply
   task automatic xchg(input logic [7:0] s, input logic [7:0] e);
      logic [7:0] g;
      fbl_host_model_i.send(s);
      get_byte(g);
      chk("reply", 32'(e), 32'(g));
   endtask
   // Reset with given mode straps, then wait past the strap latch
   task automatic do_reset(input logic hi, input logic lo);
      mode_pin_hi <= hi;
      mode_pin_lo <= lo;
      rst <= 1'b1;
      repeat (25) @(posedge ref_clk);
      rst <= 1'b0;
      ram_a.delete();
      ram_d.delete();
      jumps = 0;
      fbl_host_model_i.rx_q.delete();
      repeat (110) @(posedge ref_clk);
   endtask
   // Full boot session; fail makes the erase report an error
   task automatic boot_run(input logic fail);
      logic [7:0] p[10];
      logic [7:0] g;
      fail_mode = fail;
      for (int i = 0; i < 10; i++) begin
         seed = xs(seed);
         p[i] = (i < 8) ? BOOT_ID[63 - 8 * i -: 8] : seed[7:0];
      end
      do_reset(1'b0, 1'b0);
      chk("boot mode", 1, 32'(boot_mode));
      for (int k = 0; k < 4 && fbl_host_model_i.rx_q.size() == 0; k++)
         fbl_host_model_i.send(8'h00);
      get_byte(g);
      chk("adjust", 32'(FBL_BYTE_ADJ), 32'(g));
      xchg(FBL_BYTE_CONFIRM, FBL_BYTE_OK);
      xchg(8'h00, 8'h00);
      xchg(8'h0A, 8'h0A);
      for (int i = 0; i < 10; i++) xchg(p[i], p[i]);
      fbl_host_model_i.send(8'h5A);
      get_byte(g);
      chk("status", fail ? 32'hFF : 32'hAA, 32'(g));
      repeat (40) @(posedge ref_clk);
      chk("jumps", 32'(!fail), 32'(jumps));
      chk("divisor", BIT, 32'(baud_divisor));
      chk("frames", 0, 32'(fbl_host_model_i.frame_err));
      for (int i = 0; i < 10; i++) begin
         chk("ram addr", 32'(FBL_RAM_BASE + i), 32'(ram_a[i]));
         chk("ram data", 32'(p[i]), 32'(ram_d[i]));
      end
      watchdog_overflow <= 1'b1;
      @(posedge ref_clk);
      watchdog_overflow <= 1'b0;
      repeat (4) @(posedge ref_clk);
      chk("boot end", 0, 32'(boot_mode));
   endtask
   // Select registers in advanced (lo 0) or normal (lo 1) mode
   task automatic reg_run(input logic lo);
      logic [31:0] v;
      do_reset(1'b1, lo);
      chk("rom kb", lo ? 32'h38 : 32'h40, 32'(rom_size_kb));
      chk("normal", 32'(lo), 32'(cpu_normal_mode));
      rchk("upper rst", FBL_OFS_SEL_UPPER, 32'(FBL_SEL_RST));
      rchk("div rst", FBL_OFS_DIVISOR, 32'(FBL_DIV_RST));
      apb(1'b1, FBL_OFS_SEL_LOWER, 32'h10);
      rchk("gate off", FBL_OFS_SEL_LOWER, 0);
      apb(1'b1, FBL_OFS_CTRL, 32'h1 << FBL_CTRL_SWG_BIT);
      for (int i = 0; i < 8; i++) begin
         v = 32'h1 << i;
         apb(1'b1, FBL_OFS_SEL_LOWER, v);
         rchk("one block", FBL_OFS_SEL_LOWER, (lo && i == 7) ? 0 : v);
      end
      seed = xs(seed);
      apb(1'b1, FBL_OFS_SEL_LOWER, {25'h0, seed[6:2], 2'h3});
      rchk("two blocks", FBL_OFS_SEL_LOWER, 0);
      apb(1'b1, FBL_OFS_SEL_UPPER, 32'hFF);
      rchk("upper", FBL_OFS_SEL_UPPER, 0);
      apb(1'b1, FBL_OFS_SEL_LOWER, 32'h04);
      low_power_mode <= 1'b1;
      @(posedge ref_clk);
      low_power_mode <= 1'b0;
      rchk("low power", FBL_OFS_SEL_LOWER, 0);
      apb(1'b1, FBL_OFS_SEL_LOWER, 32'h02);
      apb(1'b1, FBL_OFS_CTRL, 0);
      rchk("gate clear", FBL_OFS_SEL_LOWER, 0);
      apb(1'b0, 8'h20, 0);
      chk("slverr", 1, 32'(rerr));
   endtask
   // Clock, 100 ns period
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   // Random read-path traffic and busy flag; word and busy flags quiet in reset
   always @(posedge ref_clk) begin
      rnd <= xs(rnd);
      flash_array_data <= rnd[15:0];
      flash_rd_addr <= {rnd[31:17], rnd[16] & ~rnd[3]};
      flash_rd_word <= rnd[3] & ~rst;
      flash_op_busy <= (rnd[7:5] == 3'h0) & ~rst;
   end
   // Erase engine stand-in with a long erase time
   initial begin
      forever begin
         @(posedge ref_clk);
         if (erase_req === 1'b1) begin
            repeat (400) @(posedge ref_clk);
            erase_done <= !fail_mode;
            erase_fail <= fail_mode;
            @(posedge ref_clk);
            {erase_done, erase_fail} <= 2'h0;
            while (erase_req === 1'b1) @(posedge ref_clk);
         end
      end
   end
   // RAM write and jump monitor
   always @(negedge ref_clk) begin
      if (ram_we === 1'b1) begin
         ram_a.push_back(ram_addr);
         ram_d.push_back(ram_wdata);
      end
      if (boot_jump === 1'b1) jumps++;
   end
   // Hang guard
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         err_count++;
         tally_and_finish();
      end
   end
   // Main sequence
   initial begin
      {psel, penable, pwrite, paddr, pwdata, low_power_mode, watchdog_overflow} = '0;
      {flash_all_ones, erase_done, erase_fail, flash_op_busy, flash_rd_word} = '0;
      {flash_rd_addr, flash_array_data, mode_pin_hi, mode_pin_lo, fail_mode} = '0;
      {boot_sel_pin_2, boot_sel_pin_1, boot_sel_pin_0} = 3'h7;
      rst = 1'b1;
      repeat (10) @(posedge ref_clk);
      boot_run(1'b0);
      boot_run(1'b1);
      reg_run(1'b0);
      reg_run(1'b1);
      tally_and_finish();
   end
endmodule // tb_top
